// >>> dnc_pkg.sv
// constants, types and register map of the drive network data image
package dnc_pkg;

  // ---------------------------------------------------------------
  // image geometry and addressing
  // ---------------------------------------------------------------
  localparam int NUM_WORDS = 10;
  localparam logic [15:0] REG_BASE = 16'h0400;
  localparam logic [15:0] REG_LAST = 16'h0409;

  // ---------------------------------------------------------------
  // output image word indices (configuration mode)
  // ---------------------------------------------------------------
  localparam logic [3:0] W_CTRL_A = 4'h0;
  localparam logic [3:0] W_CTRL_B = 4'h1;
  localparam logic [3:0] W_SPD_HI = 4'h2;
  localparam logic [3:0] W_SPD_LO = 4'h3;
  localparam logic [3:0] W_STEPS = 4'h4;
  localparam logic [3:0] W_RSVD = 4'h5;
  localparam logic [3:0] W_COUNTS = 4'h6;
  localparam logic [3:0] W_IDLE = 4'h7;
  localparam logic [3:0] W_CUR = 4'h8;
  localparam logic [3:0] W_GAIN = 4'h9;
  localparam logic [3:0] W_LAST = 4'h9;

  // ---------------------------------------------------------------
  // command mode words and input image words
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_EN_WORD = 4'h1;
  localparam logic [3:0] CMD_PARAM_FIRST = 4'h2;
  localparam logic [3:0] CMD_PARAM_SECOND = 4'h3;
  localparam logic [3:0] IN_STATUS = 4'h0;
  localparam logic [3:0] IN_MPOS_FIRST = 4'h2;
  localparam logic [3:0] IN_MPOS_SECOND = 4'h3;
  localparam logic [3:0] IN_ENC_FIRST = 4'h4;
  localparam logic [3:0] IN_ENC_SECOND = 4'h5;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  localparam int MODE_BIT = 15;
  localparam int CW0_RSVD_BIT = 9;
  localparam int CW1_BIN_OUT_BIT = 0;
  localparam int CW1_BIN_IN_BIT = 1;
  localparam int CW1_BIG_END_BIT = 2;
  localparam int CMD_EN_BIT = 15;

  // ---------------------------------------------------------------
  // ranges and codes
  // ---------------------------------------------------------------
  localparam logic signed [31:0] MW_SCALE = 32'sh0000_03e8;
  localparam logic signed [31:0] SPD_MIN = 32'sh0000_0001;
  localparam logic signed [31:0] SPD_MAX = 32'sh001e_847f;
  localparam logic [15:0] STEPS_MIN = 16'h00c8;
  localparam logic [15:0] STEPS_MAX = 16'h7fff;
  localparam logic [15:0] COUNTS_MAX = 16'h8000;
  localparam logic [15:0] IDLE_MAX = 16'h0064;
  localparam logic [15:0] CUR_MIN = 16'h000a;
  localparam logic [15:0] CUR_MAX = 16'h003c;
  localparam logic [15:0] GAIN_MIN = 16'h0001;
  localparam logic [15:0] GAIN_MAX = 16'h0028;
  localparam logic [15:0] ERR_NO_CFG = 16'h6408;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] IDX_ONE = 4'h1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [NUM_WORDS-1:0][15:0] dnc_img_t;
  typedef struct packed {
    logic bin_out;
    logic bin_in;
    logic big_end;
  } dnc_fmt_s;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } dnc_wr_s;
  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } dnc_pair_s;

endpackage : dnc_pkg

// >>> dnc_pair_enc.sv
// encoder of a 32-bit readback value into a pair of image words
`timescale 1ns/100ps
module dnc_pair_enc
  import dnc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // value and format
  input wire logic signed [31:0] val,
  input wire logic bin,
  input wire logic big_end,
  // word pair
  output dnc_pair_s pair
);

  // ---------------------------------------------------------------
  // split
  // ---------------------------------------------------------------
  localparam logic signed [31:0] MW_MIN = 32'shfe0c_0000;
  localparam logic signed [31:0] MW_MAX = 32'sh01f3_ffff;

  logic signed [31:0] quo;
  logic signed [31:0] rem;

  assign quo = val / MW_SCALE; // [R08]
  assign rem = val % MW_SCALE; // [R08]

  always_comb begin
    if (!bin) begin
      pair.first = quo[15:0]; // [R08] [R09]
      pair.second = rem[15:0];
    end else if (big_end) begin
      pair.first = val[31:16]; // [R14]
      pair.second = val[15:0];
    end else begin
      pair.first = val[15:0]; // [R14]
      pair.second = val[31:16];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mw_split: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
    (!bin && val >= MW_MIN && val <= MW_MAX) |->
      ($signed(pair.first) * MW_SCALE + $signed(pair.second) == val))
    else $error("multi-word split does not rebuild value");

  a_big_order: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    (bin && big_end) |-> ({pair.first, pair.second} == val))
    else $error("big endian word order wrong");

  a_little_order: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    (bin && !big_end) |-> ({pair.second, pair.first} == val))
    else $error("little endian word order wrong");

endmodule : dnc_pair_enc

// >>> dnc_cfg_check.sv
// range checker of a candidate configuration image
`timescale 1ns/100ps
module dnc_cfg_check
  import dnc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // candidate image
  input dnc_img_t img,
  // verdict
  output logic ok
);

  // ---------------------------------------------------------------
  // field checks
  // ---------------------------------------------------------------
  logic signed [31:0] speed;
  logic spd_ok;
  logic fld_ok;

  assign speed = $signed({{16{img[W_SPD_HI][15]}}, img[W_SPD_HI]}) * MW_SCALE
               + $signed({{16{img[W_SPD_LO][15]}}, img[W_SPD_LO]});
  assign spd_ok = (speed >= SPD_MIN) && (speed <= SPD_MAX); // [R18]

  always_comb begin
    fld_ok = 1'b1;
    if (img[W_CTRL_A][CW0_RSVD_BIT]) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_STEPS] < STEPS_MIN || img[W_STEPS] > STEPS_MAX) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_RSVD] != WORD_ZERO) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_COUNTS] > COUNTS_MAX) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_IDLE] > IDLE_MAX) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_CUR] < CUR_MIN || img[W_CUR] > CUR_MAX || img[W_CUR][0]) begin
      fld_ok = 1'b0; // [R18]
    end
    if (img[W_GAIN] < GAIN_MIN || img[W_GAIN] > GAIN_MAX) begin
      fld_ok = 1'b0; // [R18]
    end
  end

  assign ok = spd_ok && fld_ok;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rsvd_reject: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
    (img[W_RSVD] != WORD_ZERO || img[W_CUR][0]) |-> !ok)
    else $error("bad reserved word or odd current accepted");

endmodule : dnc_cfg_check

// >>> dnc_drive_image.sv
// network data image of the stepper drive: output image, config, input image
`timescale 1ns/100ps
// Summary of operation
// R01 - ten sixteen-bit words each direction
// R02 - one output bit selects the mode
// R03 - word zero bit fifteen: one configures
// R04 - power up in command mode, motor off
// R05 - apply stored config, power needs enable bit
// R06 - no config reports error code
// R07 - connection config overrides stored config
// R08 - multi-word: thousands then remainder, signed
// R09 - multi-word range limited, overflow undefined
// R10 - wide parameters and readbacks take two words
// R11 - multi-word format by default
// R12 - separate format bits per direction
// R13 - host sets both bits for 32-bit
// R14 - endian bit orders the 32-bit halves
// R15 - zero-based registers from fixed base
// R16 - host keeps start speed in range
// R17 - host writes even current tenths
// R18 - out-of-range config is invalid, motor off
module dnc_drive_image
  import dnc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host output image writes
  input dnc_wr_s host_wr,
  // host input image reads
  input wire logic host_rd,
  input wire logic [15:0] host_rd_addr,
  output logic [15:0] rd_data_ff,
  // connection supplied configuration
  input wire logic conn_cfg_apply,
  // stored configuration
  input wire logic nvm_present,
  input wire logic [15:0] nvm_data,
  output logic [3:0] nvm_idx_ff,
  // readback values
  input wire logic signed [31:0] motor_pos,
  input wire logic signed [31:0] enc_pos,
  // drive status and parameters
  output logic cfg_mode_ff,
  output logic cfg_valid_ff,
  output logic motor_power_ff,
  output logic move_enable_ff,
  output logic [31:0] cmd_param_ff,
  output dnc_fmt_s fmt_ff
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum {ST_LOAD, ST_CHECK, ST_RUN} dnc_state_e;

  dnc_state_e state_ff;
  dnc_img_t out_img_ff;
  dnc_img_t cfg_ff;
  logic cfg_ok;
  logic wr_hit;
  logic [3:0] wr_idx;
  logic rd_hit;
  logic [3:0] rd_idx;
  logic mode_now;
  logic mode_leave;
  logic en_bit;
  dnc_fmt_s nxt_fmt;
  dnc_pair_s mpos_pair;
  dnc_pair_s enc_pair;
  logic [15:0] nxt_rd_data;
  logic [31:0] nxt_cmd_param;
  logic signed [31:0] mw_param;
  logic [15:0] p_first;
  logic [15:0] p_second;
  logic [15:0] wr_off;
  logic [15:0] rd_off;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign wr_off = host_wr.addr - REG_BASE;
  assign rd_off = host_rd_addr - REG_BASE;
  assign wr_hit = host_wr.wr && host_wr.addr >= REG_BASE && host_wr.addr <= REG_LAST; // [R15]
  assign wr_idx = wr_off[3:0]; // [R15]
  assign rd_hit = host_rd_addr >= REG_BASE && host_rd_addr <= REG_LAST; // [R15]
  assign rd_idx = rd_off[3:0];

  // ---------------------------------------------------------------
  // output image
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_img_ff <= '0; // [R04]
    end else if (wr_hit) begin
      out_img_ff[wr_idx] <= host_wr.data; // [R01]
    end
  end

  // ---------------------------------------------------------------
  // mode tracking
  // ---------------------------------------------------------------
  assign mode_now = out_img_ff[W_CTRL_A][MODE_BIT]; // [R02] [R03]
  assign mode_leave = cfg_mode_ff && !mode_now;
  assign en_bit = out_img_ff[CMD_EN_WORD][CMD_EN_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_mode_ff <= 1'b0; // [R04]
    end else begin
      cfg_mode_ff <= mode_now; // [R02] [R03]
    end
  end

  // ---------------------------------------------------------------
  // configuration loading and checking
  // ---------------------------------------------------------------
  dnc_cfg_check u_check (
    .mclk(mclk),
    .rst_n(rst_n),
    .img(cfg_ff),
    .ok(cfg_ok)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_LOAD;
      cfg_ff <= '0; // [R11]
      nvm_idx_ff <= '0;
      cfg_valid_ff <= 1'b0; // [R04]
    end else if (conn_cfg_apply) begin
      cfg_ff <= out_img_ff; // [R07]
      cfg_valid_ff <= 1'b0;
      state_ff <= ST_CHECK; // [R07]
    end else begin
      case (state_ff)
        ST_LOAD: begin
          if (!nvm_present) begin
            state_ff <= ST_RUN; // [R06]
          end else begin
            cfg_ff[nvm_idx_ff] <= nvm_data; // [R05]
            if (nvm_idx_ff == W_LAST) begin
              state_ff <= ST_CHECK;
            end else begin
              nvm_idx_ff <= nvm_idx_ff + IDX_ONE;
            end
          end
        end
        ST_CHECK: begin
          cfg_valid_ff <= cfg_ok; // [R18]
          state_ff <= ST_RUN;
        end
        ST_RUN: begin
          if (mode_leave) begin
            cfg_ff <= out_img_ff; // [R02]
            cfg_valid_ff <= 1'b0;
            state_ff <= ST_CHECK;
          end
        end
        default: begin
          state_ff <= ST_LOAD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // format selection
  // ---------------------------------------------------------------
  always_comb begin
    nxt_fmt.bin_out = cfg_ff[W_CTRL_B][CW1_BIN_OUT_BIT]; // [R12]
    nxt_fmt.bin_in = cfg_ff[W_CTRL_B][CW1_BIN_IN_BIT]; // [R12]
    nxt_fmt.big_end = cfg_ff[W_CTRL_B][CW1_BIG_END_BIT]; // [R14]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fmt_ff <= '0; // [R11]
    end else if (state_ff == ST_CHECK) begin
      fmt_ff <= cfg_ok ? nxt_fmt : '0;
    end
  end

  // ---------------------------------------------------------------
  // drive enables
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      motor_power_ff <= 1'b0; // [R04]
      move_enable_ff <= 1'b0; // [R04]
    end else begin
      motor_power_ff <= cfg_valid_ff && state_ff == ST_RUN && en_bit; // [R05] [R18]
      move_enable_ff <= cfg_valid_ff && state_ff == ST_RUN && !mode_now; // [R04]
    end
  end

  // ---------------------------------------------------------------
  // command parameter decode
  // ---------------------------------------------------------------
  assign p_first = out_img_ff[CMD_PARAM_FIRST];
  assign p_second = out_img_ff[CMD_PARAM_SECOND];
  assign mw_param = $signed({{16{p_first[15]}}, p_first}) * MW_SCALE
                  + $signed({{16{p_second[15]}}, p_second}); // [R08]

  always_comb begin
    if (!fmt_ff.bin_out) begin
      nxt_cmd_param = mw_param; // [R10] [R11]
    end else if (fmt_ff.big_end) begin
      nxt_cmd_param = {p_first, p_second}; // [R14]
    end else begin
      nxt_cmd_param = {p_second, p_first}; // [R14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_param_ff <= '0;
    end else if (!mode_now) begin
      cmd_param_ff <= nxt_cmd_param; // [R10]
    end
  end

  // ---------------------------------------------------------------
  // input image
  // ---------------------------------------------------------------
  dnc_pair_enc u_mpos (
    .mclk(mclk),
    .rst_n(rst_n),
    .val(motor_pos),
    .bin(fmt_ff.bin_in),
    .big_end(fmt_ff.big_end),
    .pair(mpos_pair)
  );

  dnc_pair_enc u_enc (
    .mclk(mclk),
    .rst_n(rst_n),
    .val(enc_pos),
    .bin(fmt_ff.bin_in),
    .big_end(fmt_ff.big_end),
    .pair(enc_pair)
  );

  always_comb begin
    nxt_rd_data = WORD_ZERO;
    if (rd_hit) begin
      case (rd_idx)
        IN_STATUS: begin
          nxt_rd_data = cfg_valid_ff ? {cfg_mode_ff, 15'h0000} : ERR_NO_CFG; // [R06]
        end
        IN_MPOS_FIRST: begin
          nxt_rd_data = mpos_pair.first; // [R10]
        end
        IN_MPOS_SECOND: begin
          nxt_rd_data = mpos_pair.second;
        end
        IN_ENC_FIRST: begin
          nxt_rd_data = enc_pair.first; // [R10]
        end
        IN_ENC_SECOND: begin
          nxt_rd_data = enc_pair.second;
        end
        default: begin
          nxt_rd_data = WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (host_rd) begin
      rd_data_ff <= nxt_rd_data; // [R01]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_last_load;
    state_ff == ST_LOAD && nvm_present && nvm_idx_ff == W_LAST && !conn_cfg_apply;
  endsequence

  sequence s_checked;
    state_ff == ST_CHECK ##1 state_ff == ST_RUN;
  endsequence

  a_boot_load: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
    s_last_load |=> s_checked)
    else $error("stored config not checked after load");

  a_no_power_bad: assert property (@(posedge mclk) disable iff (!rst_n) // [R04]
    !cfg_valid_ff |=> !motor_power_ff && !move_enable_ff)
    else $error("motor powered without valid config");

  a_power_enable: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
    (cfg_valid_ff && state_ff == ST_RUN && en_bit) |=> motor_power_ff)
    else $error("motor not powered with enable bit");

  a_err_code: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
    (host_rd && host_rd_addr == REG_BASE && !cfg_valid_ff) |=> rd_data_ff == ERR_NO_CFG)
    else $error("config error code missing");

  a_mode_follow: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
    (wr_hit && wr_idx == W_CTRL_A) |=> ##1 cfg_mode_ff == $past(host_wr.data[MODE_BIT], 2))
    else $error("mode flag does not follow word zero bit");

  a_conn_apply: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
    conn_cfg_apply |=> state_ff == ST_CHECK && cfg_ff == $past(out_img_ff))
    else $error("connection config not applied");

  a_check_valid: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
    (state_ff == ST_CHECK && !conn_cfg_apply) |=> cfg_valid_ff == $past(cfg_ok))
    else $error("validity does not match checker");

  a_cfg_leave: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
    (state_ff == ST_RUN && mode_leave && !conn_cfg_apply) |=> state_ff == ST_CHECK)
    else $error("leaving config mode did not recheck");

endmodule : dnc_drive_image

// >>> dnc_nvm_model.sv
// stored configuration memory model answering the drive's word index
`timescale 1ns/100ps
module dnc_nvm_model
  import dnc_pkg::*;
(
  // index and data
  input wire logic [3:0] idx,
  output logic [15:0] data
);
  // ---------------------------------------------------------------
  // stored image, every word inside its range
  // ---------------------------------------------------------------
  dnc_img_t img;
  assign img = {16'h000a, 16'h0014, 16'h0032, 16'h0000, 16'h0000,
    16'h00c8, 16'h03e8, 16'h0000, 16'h0000, 16'h0000};
  // unused indices answer a changing pattern, not the last word
  assign data = (idx <= W_LAST) ? img[idx] : ~img[0] ^ {12'h000, idx};
endmodule : dnc_nvm_model

// >>> dnc_drive_image_tb_top.sv
// self-checking bench of the drive network data image
`timescale 1ns/100ps
module dnc_drive_image_tb_top
  import dnc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk, rst_n, host_rd, conn_cfg_apply, nvm_present;
  dnc_wr_s host_wr;
  logic [15:0] host_rd_addr, rd_data_ff, nvm_data;
  logic [3:0] nvm_idx_ff;
  logic signed [31:0] motor_pos, enc_pos;
  logic cfg_mode_ff, cfg_valid_ff, motor_power_ff, move_enable_ff;
  logic [31:0] cmd_param_ff;
  dnc_fmt_s fmt_ff;
  int n_fail, num_checks, seed;
  dnc_img_t gimg;
  // bad or boundary words: {ok, index, value}
  logic [20:0] tbl [20] = '{21'h0_0_0200, 21'h0_5_0001, 21'h0_4_00c7, 21'h0_4_8000,
    21'h0_6_8001, 21'h0_7_0065, 21'h0_8_0009, 21'h0_8_003e, 21'h0_8_0015,
    21'h0_9_0000, 21'h0_9_0029, 21'h0_3_0000, 21'h0_2_07d0, 21'h1_4_7fff,
    21'h1_6_8000, 21'h1_7_0064, 21'h1_8_003c, 21'h1_8_000a, 21'h1_9_0028,
    21'h1_9_0001};

  // ---------------------------------------------------------------
  // design and stored memory
  // ---------------------------------------------------------------
  dnc_drive_image uut (.mclk(mclk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_rd_addr(host_rd_addr), .rd_data_ff(rd_data_ff), .conn_cfg_apply(conn_cfg_apply),
    .nvm_present(nvm_present), .nvm_data(nvm_data), .nvm_idx_ff(nvm_idx_ff),
    .motor_pos(motor_pos), .enc_pos(enc_pos), .cfg_mode_ff(cfg_mode_ff),
    .cfg_valid_ff(cfg_valid_ff), .motor_power_ff(motor_power_ff),
    .move_enable_ff(move_enable_ff), .cmd_param_ff(cmd_param_ff), .fmt_ff(fmt_ff));
  dnc_nvm_model nvm (.idx(nvm_idx_ff), .data(nvm_data));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  function automatic dnc_img_t good(input logic [15:0] w1);
    good = {16'h000a, 16'h0014, 16'h0032, 16'h0000, 16'h0000,
      16'h00c8, 16'h03e8, 16'h0000, w1, 16'h0000};
  endfunction : good

  function automatic logic [31:0] exp_pair(input logic signed [31:0] v, input logic bin,
    input logic big);
    logic signed [31:0] q, r;
    q = v / 32'sd1000;
    r = v % 32'sd1000;
    if (!bin) exp_pair = {q[15:0], r[15:0]};
    else if (big) exp_pair = v;
    else exp_pair = {v[15:0], v[31:16]};
  endfunction : exp_pair

  function automatic logic [31:0] exp_par(input logic [15:0] a, input logic [15:0] b,
    input logic bin, input logic big);
    if (!bin) exp_par = $signed(a) * 32'sd1000 + $signed(b);
    else if (big) exp_par = {a, b};
    else exp_par = {b, a};
  endfunction : exp_par

  // ---------------------------------------------------------------
  // drivers and checks
  // ---------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  task automatic do_reset(input logic nvm_on);
    rst_n = 1'b0;
    nvm_present = nvm_on;
    tick(6);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    host_wr = '{1'b1, REG_BASE + {12'h000, i}, d};
    tick();
    host_wr.wr = 1'b0;
    tick();
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    host_rd = 1'b1;
    host_rd_addr = a;
    tick();
    host_rd = 1'b0;
    chk_v({16'h0000, rd_data_ff}, {16'h0000, exp});
    tick();
  endtask : rd

  task automatic apply(input dnc_img_t im);
    for (int i = 0; i < NUM_WORDS; i++) wr(i[3:0], im[i]);
    conn_cfg_apply = 1'b1;
    tick();
    conn_cfg_apply = 1'b0;
    tick(2);
  endtask : apply

  task automatic wait_valid(input int lim);
    int n;
    n = 0;
    while (cfg_valid_ff !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    chk_v({31'h0, cfg_valid_ff}, 32'h1);
  endtask : wait_valid

  task automatic pos_case(input logic signed [31:0] v, input logic bin, input logic big);
    logic [31:0] e;
    motor_pos = v;
    enc_pos = -v;
    tick(3);
    e = exp_pair(v, bin, big);
    rd(REG_BASE + 16'h2, e[31:16]);
    rd(REG_BASE + 16'h3, e[15:0]);
    e = exp_pair(-v, bin, big);
    rd(REG_BASE + 16'h4, e[31:16]);
    rd(REG_BASE + 16'h5, e[15:0]);
  endtask : pos_case

  task automatic par_case(input logic bin, input logic big);
    logic [15:0] a, b;
    a = 16'($random(seed));
    b = 16'($random(seed) % 1000);
    wr(CMD_PARAM_FIRST, a);
    wr(CMD_PARAM_SECOND, b);
    tick();
    chk_v(cmd_param_ff, exp_par(a, b, bin, big));
  endtask : par_case

  task automatic conclude();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    #(25 * 5000);
    n_fail++;
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    seed = 46247;
    n_fail = 0;
    num_checks = 0;
    host_wr = '0;
    host_rd = 1'b0;
    host_rd_addr = 16'h0000;
    conn_cfg_apply = 1'b0;
    motor_pos = 32'sh0;
    enc_pos = 32'sh0;
    do_reset(1'b0);
    tick();
    chk_v({31'h0, cfg_mode_ff}, 32'h0);
    rd(REG_BASE, ERR_NO_CFG);
    rd(REG_LAST + 16'h1, WORD_ZERO);
    rd(REG_BASE - 16'h1, WORD_ZERO);
    wr(CMD_EN_WORD, 16'h8000);
    tick();
    chk_v({29'h0, motor_power_ff, move_enable_ff, cfg_valid_ff}, 32'h0);
    tdone("power_up");
    wr(W_CTRL_A, 16'h8000);
    tick();
    chk_v({30'h0, cfg_mode_ff, move_enable_ff}, 32'h2);
    gimg = good(16'h8000);
    for (int i = 1; i < NUM_WORDS; i++) wr(i[3:0], gimg[i]);
    wr(W_CTRL_A, WORD_ZERO);
    wait_valid(8);
    tick();
    chk_v({29'h0, cfg_mode_ff, move_enable_ff, motor_power_ff}, 32'h3);
    rd(REG_BASE, WORD_ZERO);
    wr(W_CTRL_A, 16'h8000);
    tick();
    chk_v({30'h0, cfg_mode_ff, move_enable_ff}, 32'h2);
    rd(REG_BASE, 16'h8000);
    wr(W_CTRL_A, WORD_ZERO);
    tdone("mode");
    do_reset(1'b1);
    wait_valid(14);
    chk_v({28'h0, nvm_idx_ff}, 32'h9);
    chk_v({29'h0, fmt_ff}, 32'h0);
    chk_v({31'h0, motor_power_ff}, 32'h0);
    rd(REG_BASE, WORD_ZERO);
    rd(REG_LAST, WORD_ZERO);
    pos_case(32'sd12, 1'b0, 1'b0);
    pos_case(-32'sd7654321, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++) pos_case($random(seed) % 32768000, 1'b0, 1'b0);
    par_case(1'b0, 1'b0);
    wr(CMD_EN_WORD, 16'h8000);
    tick();
    chk_v({31'h0, motor_power_ff}, 32'h1);
    tdone("stored");
    for (int f = 0; f < 8; f++) begin
      apply(good({13'h0, f[2:0]}));
      chk_v({29'h0, fmt_ff}, {29'h0, f[0], f[1], f[2]});
      pos_case(32'sd1234567, f[1], f[2]);
      pos_case(-32'sd12, f[1], f[2]);
      pos_case($random(seed) % 32768000, f[1], f[2]);
      par_case(f[0], f[2]);
    end
    tdone("format");
    foreach (tbl[k]) begin
      gimg = good(16'h8000);
      gimg[tbl[k][19:16]] = tbl[k][15:0];
      apply(gimg);
      chk_v({31'h0, cfg_valid_ff}, {31'h0, tbl[k][20]});
      tick();
      chk_v({31'h0, motor_power_ff}, {31'h0, tbl[k][20]});
    end
    tdone("ranges");
    conclude();
  end
endmodule : dnc_drive_image_tb_top
